// *** core/sync_sram_regs.vh ***
`ifndef SYNC_SRAM_REGS_VH
`define SYNC_SRAM_REGS_VH
// ****************************************
// geometry
// ****************************************
`define ADDR_WIDTH      16
`define DATA_WIDTH      32
`define LANE_COUNT      4
`define BURST_BITS      2
// ****************************************
// timing counts and queue depth
// ****************************************
`define WRITE_CYCLES    2
`define FIFO_DEPTH      8
// ****************************************
// reset values
// ****************************************
`define RST_LANES_N     4'hF
`define RST_DATA        32'h0000_0000
// ****************************************
// strap encodings
// ****************************************
`define ORDER_LINEAR    1'b0
`define ORDER_INTERLEAVE 1'b1
`endif

// *** core/word_fifo.v ***
`timescale 1ns/100ps
module word_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             i_core_clk,
    input  wire             i_rst_n,
    // fill side
    input  wire             i_in_valid,
    input  wire [WIDTH-1:0] i_in_data,
    output wire             o_in_ready,
    // drain side
    output wire             o_out_valid,
    output wire [WIDTH-1:0] o_out_data,
    input  wire             i_out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign o_in_ready  = (count != DEPTH[AW:0]);
    assign o_out_valid = (count != {(AW+1){1'b0}});
    assign o_out_data  = mem[rd_ptr];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always @(posedge i_core_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // word_fifo

// *** core/burst_counter.v ***
`timescale 1ns/100ps
`include "sync_sram_regs.vh"
module burst_counter (
    // clock and reset
    input  wire       i_core_clk,
    input  wire       i_rst_n,
    // control
    input  wire       i_load,
    input  wire [1:0] i_low_addr_bits,
    input  wire       i_step,
    input  wire       i_order,
    // offset
    output wire [1:0] o_offset
);
    reg [1:0] start;
    reg [1:0] count;

    // ****************************************
    // sequencing
    // ****************************************
    function [1:0] burst_offset;
        input [1:0] base;
        input [1:0] cnt;
        input       order;
        begin
            if (order == `ORDER_LINEAR) begin
                burst_offset = base + cnt; // [R21]
            end else begin
                burst_offset = base ^ cnt; // [R21]
            end
        end
    endfunction

    assign o_offset = burst_offset(start, count, i_order);

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            start <= 2'h0;
            count <= 2'h0;
        end else if (i_load) begin
            start <= i_low_addr_bits; // [R5]
            count <= 2'h0;
        end else if (i_step) begin
            count <= count + 2'h1; // [R7]
        end
    end
endmodule // burst_counter

// *** core/sync_sram_port.v ***
// Summary of operation
// R1: every synchronous input is captured on the rising clock edge.
// R2: output enable and sleep act without the clock.
// R3: address and selects load only on an edge with an address strobe.
// R4: address picks one of 64K words when strobed with all selects active.
// R5: two low address bits load the burst counter on each new address.
// R6: later burst addresses come from the internal counter, not the pins.
// R7: burst step low at an edge advances the burst counter.
// R8: address, data and write controls register together; write is self-timed.
// R9: a write updates one to four byte lanes by lane selects.
// R10: all-bytes write low writes all four lanes, ignoring lane selects.
// R11: master drives byte write gate low with lane selects for byte writes.
// R12: lane selects act only when the byte write gate is low.
// R13: first select is active low; high makes processor strobe ignored.
// R14: first select sampled only when a new address loads.
// R15: inputs and outputs registered; read data leaves via output register.
// R16: four-word burst runs three clocks then one per word.
// R17: both strobes together: only the processor strobe acts.
// R18: order strap low selects linear, high selects interleaved.
// R19: second select active high, third active low; all three must be active.
// R20: sleep high stops activity and keeps contents.
// R21: burst wraps in four; interleave xors, linear adds modulo four.
// R22: no strobe and step high repeats the same word.
`timescale 1ns/100ps
`include "sync_sram_regs.vh"
module sync_sram_port #(
    parameter ADDR_WIDTH = `ADDR_WIDTH,
    parameter DATA_WIDTH = `DATA_WIDTH,
    parameter FIFO_DEPTH = `FIFO_DEPTH
) (
    // clock and reset
    input  wire                  i_core_clk,
    input  wire                  i_rst_n,
    // address and strobes
    input  wire [ADDR_WIDTH-1:0] i_addr,
    input  wire                  i_proc_addr_strobe_n,
    input  wire                  i_ctrl_addr_strobe_n,
    input  wire                  i_burst_step_n,
    // chip selects
    input  wire                  i_select_pipe_n,
    input  wire                  i_select_depth_high,
    input  wire                  i_select_depth_low_n,
    // write controls
    input  wire                  i_all_bytes_write_n,
    input  wire                  i_byte_write_gate_n,
    input  wire [3:0]            i_lane_write_sel_n,
    // static and asynchronous controls
    input  wire                  i_burst_order,
    input  wire                  i_output_enable_n,
    input  wire                  i_sleep_request,
    // data pins, split three ways
    input  wire [DATA_WIDTH-1:0] i_dq,
    output reg  [DATA_WIDTH-1:0] o_dq,
    output reg                   o_dq_oe_n,
    // status
    output reg                   o_sleeping,
    output reg                   o_write_busy,
    output reg                   o_read_valid
);
    // ****************************************
    // storage
    // ****************************************
    reg [DATA_WIDTH-1:0] mem [0:(1<<ADDR_WIDTH)-1];

    // ****************************************
    // input stage
    // ****************************************
    reg [ADDR_WIDTH-1:0] addr_reg;
    reg                  selected;
    reg                  burst_active;
    reg                  order_strap;
    reg                  strap_taken;
    reg [DATA_WIDTH-1:0] wdata_reg;
    reg [3:0]            lanes_n_reg;
    reg                  write_pend;
    reg                  read_pend;
    reg                  read_stage;
    reg [DATA_WIDTH-1:0] read_word;

    wire proc_take = !i_proc_addr_strobe_n && !i_select_pipe_n;       // [R13]
    wire ctrl_take = !i_ctrl_addr_strobe_n && i_proc_addr_strobe_n;   // [R17]
    wire new_addr  = (proc_take || ctrl_take) && !i_sleep_request;    // [R3]
    wire sel_now   = !i_select_pipe_n && i_select_depth_high
                     && !i_select_depth_low_n;                         // [R19]
    wire step      = !new_addr && !i_burst_step_n && burst_active
                     && !i_sleep_request;                              // [R7]
    // write shows up with the write controls on any selected cycle
    wire [3:0] gate_lanes = i_byte_write_gate_n ? 4'hF : i_lane_write_sel_n; // [R12]
    wire [3:0] lanes_n    = !i_all_bytes_write_n ? 4'h0 : gate_lanes;        // [R10] [R11]
    wire wr_now = (lanes_n != 4'hF);
    wire cycle_sel = new_addr ? sel_now : selected; // [R14]

    wire [1:0] offset;
    burst_counter u_burst (
        .i_core_clk      (i_core_clk),
        .i_rst_n         (i_rst_n),
        .i_load          (new_addr),
        .i_low_addr_bits (i_addr[1:0]),
        .i_step          (step),
        .i_order         (order_strap),
        .o_offset        (offset)
    );

    // later words come from the counter, not the pins
    wire [ADDR_WIDTH-1:0] word_addr = {addr_reg[ADDR_WIDTH-1:2], offset}; // [R6] [R4]

    // ****************************************
    // address and select registers
    // ****************************************
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_reg     <= {ADDR_WIDTH{1'b0}};
            selected     <= 1'b0;
            burst_active <= 1'b0;
            order_strap  <= `ORDER_INTERLEAVE;
            strap_taken  <= 1'b0;
        end else begin
            if (!strap_taken) begin
                order_strap <= i_burst_order; // [R18]
                strap_taken <= 1'b1;
            end
            if (new_addr) begin
                addr_reg     <= i_addr;  // [R1] [R3]
                selected     <= sel_now; // [R14]
                burst_active <= sel_now;
            end
        end
    end

    // ****************************************
    // write path: data queued with its address
    // ****************************************
    localparam WQ_W = DATA_WIDTH + ADDR_WIDTH + 4;
    localparam [31:0] WTIMER_LOAD = `WRITE_CYCLES - 1;
    wire            wq_in_ready;
    wire            wq_out_valid;
    wire [WQ_W-1:0] wq_out_data;
    reg             wq_in_valid;
    reg  [ADDR_WIDTH-1:0] waddr_reg;
    reg  [1:0]      wtimer;
    wire            wq_pop = wq_out_valid && (wtimer == 2'h0) && !i_sleep_request;

    word_fifo #(
        .WIDTH (WQ_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    ) u_wq (
        .i_core_clk  (i_core_clk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (wq_in_valid),
        .i_in_data   ({waddr_reg, lanes_n_reg, wdata_reg}),
        .o_in_ready  (wq_in_ready),
        .o_out_valid (wq_out_valid),
        .o_out_data  (wq_out_data),
        .i_out_ready (wq_pop)
    );

    // registered capture of data and controls together
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wdata_reg   <= `RST_DATA;
            lanes_n_reg <= `RST_LANES_N;
            waddr_reg   <= {ADDR_WIDTH{1'b0}};
            wq_in_valid <= 1'b0;
        end else begin
            wdata_reg   <= i_dq;            // [R1] [R8]
            lanes_n_reg <= lanes_n;         // [R9]
            waddr_reg   <= new_addr ? {i_addr[ADDR_WIDTH-1:2], i_addr[1:0]} : word_addr;
            // a full queue drops the write; the master must pace writes
            wq_in_valid <= cycle_sel && wr_now && !i_sleep_request && wq_in_ready; // [R8]
        end
    end

    // self-timed commit, one queued write per WRITE_CYCLES
    integer ln;
    always @(posedge i_core_clk) begin
        if (wq_pop) begin
            for (ln = 0; ln < 4; ln = ln + 1) begin
                if (!wq_out_data[DATA_WIDTH+ln]) begin
                    mem[wq_out_data[WQ_W-1:DATA_WIDTH+4]][ln*8 +: 8]
                        <= wq_out_data[ln*8 +: 8]; // [R9]
                end
            end
        end
    end

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wtimer       <= 2'h0;
            o_write_busy <= 1'b0;
        end else begin
            if (wq_pop) begin
                wtimer <= WTIMER_LOAD[1:0]; // [R8]
            end else if (wtimer != 2'h0) begin
                wtimer <= wtimer - 2'h1;
            end
            o_write_busy <= wq_out_valid || wq_in_valid || (wtimer != 2'h0);
        end
    end

    // ****************************************
    // read pipeline: address reg, array, output reg
    // ****************************************
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            read_pend  <= 1'b0;
            read_stage <= 1'b0;
            read_word  <= `RST_DATA;
        end else begin
            // repeat of same word when no strobe and step high [R22]
            read_pend  <= cycle_sel && !wr_now && !i_sleep_request;
            read_stage <= read_pend;
            if (read_pend) begin
                read_word <= mem[word_addr]; // [R15]
            end
        end
    end

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dq         <= `RST_DATA;
            o_read_valid <= 1'b0;
        end else begin
            o_read_valid <= read_stage; // [R16]
            if (read_stage) begin
                o_dq <= read_word;      // [R15]
            end
        end
    end

    // ****************************************
    // asynchronous controls
    // ****************************************
    // oe and sleep act on the flop's async path so they take effect without an edge
    always @(posedge i_core_clk or posedge i_output_enable_n) begin
        if (i_output_enable_n) begin
            o_dq_oe_n <= 1'b1; // [R2]
        end else begin
            // read_stage only follows a selected read; gating on selected would cut
            // the last words of a burst short when a deselect arrives behind it
            o_dq_oe_n <= !read_stage;
        end
    end

    always @(posedge i_core_clk or posedge i_sleep_request) begin
        if (i_sleep_request) begin
            o_sleeping <= 1'b1; // [R2] [R20]
        end else begin
            o_sleeping <= 1'b0;
        end
    end
endmodule // sync_sram_port

// *** bench/sram_port_checker.sv ***
`timescale 1ns/100ps
module sram_port_checker (
    // clock, reset and inputs
    input wire        i_core_clk,
    input wire        i_rst_n,
    input wire        i_proc_addr_strobe_n,
    input wire        i_ctrl_addr_strobe_n,
    input wire        i_burst_step_n,
    input wire        i_select_pipe_n,
    input wire        i_select_depth_high,
    input wire        i_select_depth_low_n,
    input wire        i_all_bytes_write_n,
    input wire        i_byte_write_gate_n,
    input wire [3:0]  i_lane_write_sel_n,
    input wire        i_output_enable_n,
    input wire        i_sleep_request,
    // outputs
    input wire [31:0] o_dq,
    input wire        o_dq_oe_n,
    input wire        o_sleeping,
    input wire        o_write_busy,
    input wire        o_read_valid
);
    // ****************************************
    // access decode and properties
    // ****************************************
    wire nw  = !i_sleep_request && ((!i_proc_addr_strobe_n && !i_select_pipe_n)
               || (!i_ctrl_addr_strobe_n && i_proc_addr_strobe_n));
    wire sel = !i_select_pipe_n && i_select_depth_high && !i_select_depth_low_n;
    wire wr  = !i_all_bytes_write_n || (!i_byte_write_gate_n && !(&i_lane_write_sel_n));
    wire rd  = nw && sel && !wr;
    wire stp = i_proc_addr_strobe_n && i_ctrl_addr_strobe_n && !i_burst_step_n;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    oe_async_a: assert property (i_output_enable_n |-> o_dq_oe_n)
        else $error("pins driven while disabled");
    sleep_flag_a: assert property (i_sleep_request |-> o_sleeping)
        else $error("sleep not flagged");
    read_latency_a: assert property (rd |-> ##[2:4] o_read_valid)
        else $error("read word late");
    burst_rate_a: assert property (rd ##1 stp [*3] |-> ##[0:1] o_read_valid [*3])
        else $error("burst words not back to back");
    write_busy_a: assert property (nw && sel && wr |-> ##[1:2] o_write_busy)
        else $error("write not started");
    oe_drive_a: assert property (o_read_valid && !i_output_enable_n && !$past(i_output_enable_n) |-> !o_dq_oe_n)
        else $error("read word not driven");
    sleep_quiet_a: assert property (i_sleep_request [*5] |-> !o_read_valid)
        else $error("read while asleep");
    dq_hold_a: assert property ($changed(o_dq) |-> o_read_valid)
        else $error("read data moved without a word");
endmodule // sram_port_checker
bind sync_sram_port sram_port_checker chk (.i_core_clk, .i_rst_n, .i_proc_addr_strobe_n,
    .i_ctrl_addr_strobe_n, .i_burst_step_n, .i_select_pipe_n, .i_select_depth_high,
    .i_select_depth_low_n, .i_all_bytes_write_n, .i_byte_write_gate_n, .i_lane_write_sel_n,
    .i_output_enable_n, .i_sleep_request, .o_dq, .o_dq_oe_n, .o_sleeping, .o_write_busy,
    .o_read_valid);

// *** bench/bus_master.sv ***
`timescale 1ns/100ps
module bus_master (
    // clock
    input  wire        i_core_clk,
    // bus toward the port
    output reg  [15:0] o_addr,
    output reg         o_pstb_n,
    output reg         o_cstb_n,
    output reg         o_step_n,
    output reg  [2:0]  o_sel,
    output reg         o_gw_n,
    output reg         o_bwe_n,
    output reg  [3:0]  o_lanes_n,
    output reg  [31:0] o_dq
);
    // ****************************************
    // bus cycles
    // ****************************************
    initial begin
        {o_pstb_n, o_cstb_n, o_step_n, o_gw_n, o_bwe_n, o_sel} = 8'hFD;
        o_addr = 16'h0000;
        o_lanes_n = 4'hF;
        o_dq = 32'h0000_0000;
    end
    // byte writes carry the gate low together with the lane selects
    task put(input p, input c, input [15:0] a, input [2:0] s, input g, input b, input [3:0] l,
             input [31:0] d);
        @(posedge i_core_clk);
        {o_pstb_n, o_cstb_n, o_step_n, o_addr, o_sel, o_gw_n, o_bwe_n, o_lanes_n, o_dq} <=
            {p, c, 1'b1, a, s, g, b, l, d};
    endtask
    // released address and data lines toggle so a stale value never passes for a fresh one
    task idle(input st);
        @(posedge i_core_clk);
        {o_pstb_n, o_cstb_n, o_step_n, o_gw_n, o_bwe_n, o_sel} <= {2'b11, st, 5'h1D};
        o_addr <= ~o_addr;
        o_dq <= ~o_dq;
    endtask
endmodule // bus_master

// *** bench/sync_sram_port_tb.sv ***
`timescale 1ns/100ps
module sync_sram_port_tb;
    // ****************************************
    // stimulus and checking
    // ****************************************
    reg          i_core_clk = 1'b0;
    reg          i_rst_n = 1'b0;
    reg          i_burst_order = 1'b0;
    reg          i_output_enable_n = 1'b0;
    reg          i_sleep_request = 1'b0;
    wire [15:0]  i_addr;
    wire         i_proc_addr_strobe_n, i_ctrl_addr_strobe_n, i_burst_step_n;
    wire         i_select_pipe_n, i_select_depth_high, i_select_depth_low_n;
    wire         i_all_bytes_write_n, i_byte_write_gate_n;
    wire [3:0]   i_lane_write_sel_n;
    wire [31:0]  i_dq, o_dq;
    wire         o_dq_oe_n, o_sleeping, o_write_busy, o_read_valid;
    reg [31:0]   mem [0:65535];
    integer      seed = 5, n_fail = 0, n_tests = 0, k, j, t, r;
    reg [15:0]   base;
    reg [31:0]   rv;
    initial forever #2.5 i_core_clk = ~i_core_clk;
    sync_sram_port DUT (.i_core_clk, .i_rst_n, .i_addr, .i_proc_addr_strobe_n,
        .i_ctrl_addr_strobe_n, .i_burst_step_n, .i_select_pipe_n, .i_select_depth_high,
        .i_select_depth_low_n, .i_all_bytes_write_n, .i_byte_write_gate_n, .i_lane_write_sel_n,
        .i_burst_order, .i_output_enable_n, .i_sleep_request, .i_dq, .o_dq, .o_dq_oe_n,
        .o_sleeping, .o_write_busy, .o_read_valid);
    bus_master m (.i_core_clk, .o_addr(i_addr), .o_pstb_n(i_proc_addr_strobe_n),
        .o_cstb_n(i_ctrl_addr_strobe_n), .o_step_n(i_burst_step_n),
        .o_sel({i_select_pipe_n, i_select_depth_high, i_select_depth_low_n}),
        .o_gw_n(i_all_bytes_write_n), .o_bwe_n(i_byte_write_gate_n),
        .o_lanes_n(i_lane_write_sel_n), .o_dq(i_dq));
    function [31:0] merge(input [31:0] old, input [31:0] d, input g, input b, input [3:0] l);
        integer q;
        merge = old;
        for (q = 0; q < 4; q++)
            if (!g || (!b && !l[q])) merge[8*q +: 8] = d[8*q +: 8];
    endfunction
    function [1:0] boff(input [1:0] st, input [1:0] n);
        boff = i_burst_order ? st ^ n : st + n;
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task timeout;
        n_fail++;
        $display("ERROR t=%0t wait ran out", $time);
        tally_and_finish;
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task wr(input p, input c, input [15:0] a, input [2:0] s, input g, input b, input [3:0] l,
            input [31:0] d);
        m.put(p, c, a, s, g, b, l, d);
        m.idle(1'b1);
        if (s == 3'b010 && !i_sleep_request) mem[a] = merge(mem[a], d, g, b, l);
        for (k = 0; k < 16 && (k < 3 || o_write_busy !== 1'b0); k++) @(negedge i_core_clk);
        if (k == 16) timeout;
    endtask
    // a deselected strobe first ends any running burst, so the first word found is fresh
    task rd(input p, input c, input [1:0] st);
        m.put(1'b1, 1'b0, base, 3'b101, 1'b1, 1'b1, 4'hF, 32'h0000_0000);
        repeat (3) m.idle(1'b1);
        m.put(p, c, {base[15:2], st}, 3'b010, 1'b1, 1'b1, 4'hF, 32'h0000_0000);
        fork
            begin
                repeat (3) m.idle(1'b0);
                m.idle(1'b1);
            end
            begin
                for (k = 0; k < 6 && o_read_valid !== 1'b1; k++) @(negedge i_core_clk);
                if (k == 6) timeout;
                for (j = 0; j < 4; j++) begin
                    check(o_dq, mem[{base[15:2], boff(st, j[1:0])}]);
                    check({31'h0, o_read_valid}, 32'h1);
                    check({31'h0, o_dq_oe_n}, {31'h0, i_output_enable_n});
                    @(negedge i_core_clk);
                end
            end
        join
        repeat (3) m.idle(1'b1);
        @(negedge i_core_clk);
        check(o_dq, mem[{base[15:2], boff(st, 2'h3)}]);
    endtask
    initial begin
        for (r = 0; r < 2; r++) begin
            @(posedge i_core_clk);
            i_rst_n <= 1'b0;
            i_burst_order <= r[0];
            repeat (5) @(posedge i_core_clk);
            i_rst_n <= 1'b1;
            rv = $random(seed);
            base = rv[15:0];
            for (t = 0; t < 4; t++) begin
                rv = $random(seed);
                wr(rv[0], rv[1] & ~rv[0], {base[15:2], t[1:0]}, 3'b010, 1'b0, rv[2], rv[6:3],
                   $random(seed));
            end
            wr(1'b1, 1'b0, base, 3'b010, 1'b1, 1'b1, 4'h0, $random(seed));
            wr(1'b1, 1'b0, base + 16'h0001, 3'b010, 1'b0, 1'b0, 4'hE, $random(seed));
            for (t = 0; t < 8; t++) begin
                rv = $random(seed);
                wr(1'b1, 1'b0, {base[15:2], rv[1:0]}, 3'b010, 1'b1, rv[2], rv[6:3], $random(seed));
            end
            for (t = 0; t < 3; t++)
                wr(~(t[0] | t[1]), t[0] | t[1], {base[15:2], t[1:0]}, 3'(9'h183 >> (3 * t)), 1'b0, 1'b1,
                   4'hF, $random(seed));
            $display("writes done, order %0d", r);
            @(posedge i_core_clk);
            i_sleep_request <= 1'b1;
            wr(1'b1, 1'b0, base, 3'b010, 1'b0, 1'b1, 4'hF, $random(seed));
            repeat (6) @(negedge i_core_clk);
            check({31'h0, o_sleeping}, 32'h1);
            @(posedge i_core_clk);
            i_sleep_request <= 1'b0;
            $display("sleep done, order %0d", r);
            for (t = 0; t < 4; t++) begin
                rv = $random(seed);
                @(posedge i_core_clk);
                i_output_enable_n <= (t == 3);
                rd(rv[0], rv[1] & ~rv[0], t[1:0]);
                @(posedge i_core_clk);
                i_output_enable_n <= 1'b0;
            end
            $display("bursts done, order %0d", r);
        end
        tally_and_finish;
    end
endmodule // sync_sram_port_tb
